// *** hw/stc_pkg.sv ***
/*
 Shared constants and types for the stepper translator and chopper.
 Assumes a single 100 MHz reference clock feeding all logic.
*/
package stc_pkg;

	// ==========================================
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int CYC_PER_US    = 1000 / CLK_PERIOD_NS;
	localparam int OFF_DEF_US    = 30;
	localparam int OFF_DEF_CYC   = OFF_DEF_US * CYC_PER_US;
	localparam int RES_DIV       = 825;
	localparam int BLANK_NS      = 1000;
	localparam int BLANK_CYC     = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FAST_NUM      = 5;
	localparam int FAST_SHIFT    = 4;
	localparam int OFF_W         = 17;

	// ==========================================
	// register port
	localparam logic [7:0]  ADDR_CTRL = 8'h00;
	localparam logic [7:0]  ADDR_STAT = 8'h04;
	localparam logic [19:0] RES_RST   = 20'h060ae;

	// ==========================================
	// synchronised pin vector
	localparam int SYNC_W   = 14;
	localparam int SI_STEP  = 0;
	localparam int SI_DIR   = 1;
	localparam int SI_SIZE  = 2;
	localparam int SI_RSTN  = 3;
	localparam int SI_ENA_N = 4;
	localparam int SI_OTSP  = 5;
	localparam int SI_TRIP  = 6;
	localparam int SI_ZERO  = 8;
	localparam int SI_GREG  = 10;
	localparam int SI_PUMP  = 11;
	localparam int SI_OT    = 12;
	localparam int SI_LOCK  = 13;
	localparam logic [SYNC_W-1:0] SYNC_RST = 14'h2010;

	// ==========================================
	// translator
	localparam logic [2:0] HOME_POS = 3'h1;
	localparam logic [1:0] MAG_0    = 2'h0;
	localparam logic [1:0] MAG_70   = 2'h1;
	localparam logic [1:0] MAG_100  = 2'h2;

	typedef enum logic [1:0] {CH_DRIVE = 2'b01, CH_OFF = 2'b10} stc_chop_t;

	typedef struct packed {
		logic       neg;
		logic [1:0] mag;
	} stc_phase_t;

	typedef struct packed {
		logic src_a;
		logic snk_a;
		logic src_b;
		logic snk_b;
	} stc_gate_t;

endpackage

// *** hw/stc_translator_chop.sv ***
/*
 Step translator, fixed off-time chopper with blanking, automatic decay
 selection, synchronous rectification and fault shutdown for two bridges.
 Assumes pins and comparator outputs arrive asynchronous to ref_clk and
 that software sets the timing resistor value over the register port.
*/
// How it works
// - trip holds bridge off for fixed off-time
// - setting pin high gives 30 us default
// - trip comparators ignored 1 us after each trip, and 1 us after an off-time only if that off-time is longer than 1 us
// - gate regulator fault disables all outputs
// - enable pin high forces outputs off
// - translator keeps stepping whatever enable does
// - overtemp or pump undervoltage disables outputs
// - lockout disables outputs, sends translator home
// - mixed decay: fast for 5/16 off-time
// - off-time recirculates per selected decay
// - decay uses active synchronous rectification
// - zero current stops synchronous rectification
// - eight-position table, full steps on diagonals
// - step rising edge advances, direction sampled
// - size select: low full, high half
// - falling level or reset to home mixed, else slow decay
// - reset low holds home, ignores steps
`timescale 1ns/10ps
module stc_translator_chop import stc_pkg::*; (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	// controller pins
	input  wire logic             step_pin,
	input  wire logic             dir_pin,
	input  wire logic             step_size_select,
	input  wire logic             translator_reset_n,
	input  wire logic             enable_n,
	input  wire logic             off_time_set_pin,
	// current sense and supervisors
	input  wire logic [1:0]       trip,
	input  wire logic [1:0]       zero_current,
	input  wire logic             gate_regulator_rail_fault,
	input  wire logic             charge_pump_rail_uv,
	input  wire logic             overtemp,
	input  wire logic             undervoltage_lockout,
	// register port
	input  wire logic [7:0]       reg_addr,
	input  wire logic [31:0]      reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic [31:0]           reg_rdata,
	// bridge drive
	output stc_gate_t [1:0]       gate,
	output stc_phase_t [1:0]      dac_level,
	output logic [1:0]            decay_mixed
);

	// ==========================================
	// pin synchronisers
	logic [SYNC_W-1:0] s1;
	logic [SYNC_W-1:0] s2;
	logic [SYNC_W-1:0] s3;
	logic [SYNC_W-1:0] pin_q;
	wire  [SYNC_W-1:0] raw = {undervoltage_lockout, overtemp, charge_pump_rail_uv,
		gate_regulator_rail_fault, zero_current, trip, off_time_set_pin, enable_n,
		translator_reset_n, step_size_select, dir_pin, step_pin};
	wire  [SYNC_W-1:0] agree = ~(s2 ^ s3);
	wire  [SYNC_W-1:0] next_pin_q = (agree & s3) | (~agree & pin_q);

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			s1    <= SYNC_RST;
			s2    <= SYNC_RST;
			s3    <= SYNC_RST;
			pin_q <= SYNC_RST;
		end
		else
		begin
			s1    <= raw;
			s2    <= s1;
			s3    <= s2;
			pin_q <= next_pin_q;
		end
	end

	// ==========================================
	// registers
	logic [19:0] res_ohm;
	logic [26:0] res_scaled;
	logic [OFF_W-1:0] off_res_cyc;
	logic [OFF_W-1:0] off_cyc;
	logic [OFF_W-1:0] fast_cyc;
	logic [OFF_W+2:0] fast_prod;
	wire off_time_set_pin_q = pin_q[SI_OTSP];
	wire wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);

	assign res_scaled = 27'(res_ohm) * 27'(CYC_PER_US);
	assign off_res_cyc = OFF_W'(res_scaled / 27'(RES_DIV));
	// a zero-length off-time would let the chopper spin, so one cycle is the floor
	assign off_cyc = off_time_set_pin_q ? OFF_W'(OFF_DEF_CYC) :
		(off_res_cyc == '0) ? OFF_W'(1) : off_res_cyc;
	assign fast_prod = (OFF_W+3)'(off_cyc) * (OFF_W+3)'(FAST_NUM);
	assign fast_cyc = OFF_W'(fast_prod >> FAST_SHIFT);

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			res_ohm <= RES_RST;
		else if (wr_ctrl)
			res_ohm <= reg_wdata[19:0];
	end

	// ==========================================
	// translator
	logic [2:0] pos;
	logic       step_prev;
	stc_chop_t  st [2];

	function automatic stc_phase_t phase_of(input logic [2:0] i);
		stc_phase_t p;
		p.neg = (i >= 3'h3) && (i <= 3'h5);
		p.mag = (i == 3'h0 || i == 3'h4) ? MAG_100 :
			(i == 3'h2 || i == 3'h6) ? MAG_0 : MAG_70;
		return p;
	endfunction

	wire hold_home = ~pin_q[SI_RSTN] | pin_q[SI_LOCK];
	wire step_rise = pin_q[SI_STEP] & ~step_prev & ~hold_home;
	wire full_mode = ~pin_q[SI_SIZE];
	// full steps land on the diagonal positions only
	wire [2:0] stride = (full_mode && pos[0]) ? 3'h2 : 3'h1;
	wire [2:0] next_pos = pin_q[SI_DIR] ? pos + stride : pos - stride;
	wire stc_phase_t new1 = phase_of(next_pos);
	wire stc_phase_t new2 = phase_of(next_pos - 3'h2);
	wire stc_phase_t old1 = phase_of(pos);
	wire stc_phase_t old2 = phase_of(pos - 3'h2);

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			step_prev <= 1'b0;
		else
			step_prev <= pin_q[SI_STEP];
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n || hold_home)
		begin
			pos          <= HOME_POS;
			dac_level[0] <= phase_of(HOME_POS);
			dac_level[1] <= phase_of(HOME_POS - 3'h2);
			decay_mixed  <= 2'b11;
		end
		else if (step_rise)
		begin
			pos          <= next_pos;
			dac_level[0] <= new1;
			dac_level[1] <= new2;
			decay_mixed  <= {new2.mag < old2.mag, new1.mag < old1.mag};
		end
	end

	// ==========================================
	// shutdown
	wire kill = pin_q[SI_ENA_N] | pin_q[SI_GREG] | pin_q[SI_PUMP] | pin_q[SI_OT]
		| hold_home;

	// ==========================================
	// per-bridge chopper
	genvar k;
	generate
		for (k = 0; k < 2; k++)
		begin : g_br
			logic [OFF_W-1:0] elapsed;
			logic [7:0]       blank;
			stc_gate_t        next_gate;
			wire stc_phase_t  lvl = dac_level[k];
			wire trip_ok = (st[k] == CH_DRIVE) && (blank == 8'h00)
				&& pin_q[SI_TRIP+k];
			wire off_end = (st[k] == CH_OFF) && (elapsed >= off_cyc - OFF_W'(1));
			wire fast = decay_mixed[k] && (elapsed < fast_cyc);
			wire zc = pin_q[SI_ZERO+k];

			always_ff @(posedge ref_clk)
			begin
				if (!rst_n)
				begin
					st[k]   <= CH_DRIVE;
					elapsed <= '0;
					blank   <= 8'(BLANK_CYC);
				end
				else
				begin
					case (st[k])
						CH_DRIVE:
						begin
							if (trip_ok)
							begin
								st[k]   <= CH_OFF;
								elapsed <= '0;
								blank   <= 8'(BLANK_CYC);
							end
							else if (blank != 8'h00)
								blank <= blank - 8'h01;
						end
						CH_OFF:
						begin
							if (off_end)
							begin
								st[k] <= CH_DRIVE;
								blank <= 8'(BLANK_CYC);
							end
							else
								elapsed <= elapsed + OFF_W'(1);
							if (blank != 8'h00)
								blank <= blank - 8'h01;
						end
						default:
							st[k] <= CH_DRIVE;
					endcase
				end
			end

			always_comb
			begin
				next_gate = '0;
				if (!kill && lvl.mag != MAG_0)
				begin
					if (st[k] == CH_DRIVE)
					begin
						next_gate.src_a = ~lvl.neg;
						next_gate.snk_b = ~lvl.neg;
						next_gate.src_b = lvl.neg;
						next_gate.snk_a = lvl.neg;
					end
					else if (!zc)
					begin
						if (fast)
						begin
							next_gate.src_a = lvl.neg;
							next_gate.snk_b = lvl.neg;
							next_gate.src_b = ~lvl.neg;
							next_gate.snk_a = ~lvl.neg;
						end
						else
						begin
							next_gate.snk_a = 1'b1;
							next_gate.snk_b = 1'b1;
						end
					end
				end
			end

			always_ff @(posedge ref_clk)
			begin
				if (!rst_n)
					gate[k] <= '0;
				else
					gate[k] <= next_gate;
			end

			sequence s_trip_taken;
				(st[k] == CH_DRIVE) && trip_ok;
			endsequence

			property p_trip_off;
				@(posedge ref_clk) disable iff (!rst_n)
				s_trip_taken |=> (st[k] == CH_OFF) && (elapsed == '0);
			endproperty
			a_trip_off: assert property (p_trip_off)
				else $error("trip did not start off-time");

			property p_blank_ignore;
				@(posedge ref_clk) disable iff (!rst_n)
				(st[k] == CH_DRIVE && blank != 8'h00) |=> st[k] == CH_DRIVE;
			endproperty
			a_blank_ignore: assert property (p_blank_ignore)
				else $error("trip accepted during blanking");

			property p_off_len;
				@(posedge ref_clk) disable iff (!rst_n)
				(st[k] == CH_OFF && elapsed == off_cyc - OFF_W'(1)
					&& $stable(off_cyc)) |=> st[k] == CH_DRIVE;
			endproperty
			a_off_len: assert property (p_off_len)
				else $error("off-time length wrong");

			property p_zero_cut;
				@(posedge ref_clk) disable iff (!rst_n)
				(st[k] == CH_OFF && zc) |=> gate[k] == '0;
			endproperty
			a_zero_cut: assert property (p_zero_cut)
				else $error("rectification kept on at zero current");
		end
	endgenerate

	// ==========================================
	// read port
	wire [31:0] stat_word = {22'h000000, kill, st[1], st[0],
		decay_mixed, pos};
	wire [31:0] rd_mux = (reg_addr == ADDR_CTRL) ? {12'h000, res_ohm} :
		(reg_addr == ADDR_STAT) ? stat_word : 32'h0000_0000;

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			reg_rdata <= 32'h0000_0000;
		else
			reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
	end

	// ==========================================
	// checks
	property p_kill_off;
		@(posedge ref_clk) disable iff (!rst_n)
		kill |=> (gate[0] == '0) && (gate[1] == '0);
	endproperty
	a_kill_off: assert property (p_kill_off)
		else $error("bridge driven while disabled");

	property p_step_moves;
		@(posedge ref_clk) disable iff (!rst_n)
		step_rise |=> pos != $past(pos);
	endproperty
	a_step_moves: assert property (p_step_moves)
		else $error("step edge did not move translator");

	property p_home;
		@(posedge ref_clk) disable iff (!rst_n)
		hold_home |=> pos == HOME_POS;
	endproperty
	a_home: assert property (p_home)
		else $error("translator not home while held");

	property p_full_diag;
		@(posedge ref_clk) disable iff (!rst_n)
		(step_rise && full_mode) |=> pos[0];
	endproperty
	a_full_diag: assert property (p_full_diag)
		else $error("full step left diagonal");

	property p_decay_sel;
		@(posedge ref_clk) disable iff (!rst_n)
		step_rise |=> decay_mixed[0] == ($past(new1.mag) < $past(old1.mag));
	endproperty
	a_decay_sel: assert property (p_decay_sel)
		else $error("decay selection wrong");

	property p_def_off;
		@(posedge ref_clk) disable iff (!rst_n)
		off_time_set_pin_q |-> off_cyc == OFF_W'(OFF_DEF_CYC);
	endproperty
	a_def_off: assert property (p_def_off)
		else $error("default off-time not 30 us");

endmodule

// *** dv/stc_ctrl_model.sv ***
/*
 Controller model: one step pulse per request, levels set before it.
 Assumes a request only while done is high.
*/
`timescale 1ns/10ps
module stc_ctrl_model (
	// clock
	input  wire logic ref_clk,
	// request
	input  wire logic go,
	input  wire logic dir_req,
	input  wire logic size_req,
	output logic      done,
	// step pins
	output logic      step_pin,
	output logic      dir_pin,
	output logic      step_size_select
);
	initial
	begin
		done = 1'b1;
		step_pin = 1'b0;
		dir_pin = 1'b0;
		step_size_select = 1'b0;
	end
	always @(posedge ref_clk)
	begin
		if (go)
		begin
			done <= 1'b0;
			dir_pin <= dir_req;
			step_size_select <= size_req;
			// setup ahead of the edge, levels held until the next request
			repeat (4) @(posedge ref_clk);
			step_pin <= 1'b1;
			// pulses wider than the synchroniser needs
			repeat (8) @(posedge ref_clk);
			step_pin <= 1'b0;
			repeat (8) @(posedge ref_clk);
			done <= 1'b1;
		end
	end
endmodule

// *** dv/test_stc_translator_chop.sv ***
/*
 Bench for the translator and chopper: steps, kills, off-time, registers.
 Assumes the controller model in stc_ctrl_model drives the step pins.
*/
`timescale 1ns/10ps
module test_stc_translator_chop;
	import stc_pkg::*;
	localparam int R_SET = 1650;
	localparam int OFF_CYC = R_SET * 100 / RES_DIV;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic go = 1'b0;
	logic dir_req = 1'b0;
	logic size_req = 1'b0;
	logic done;
	logic step_pin;
	logic dir_pin;
	logic step_size_select;
	logic translator_reset_n = 1'b1;
	logic enable_n = 1'b0;
	logic off_time_set_pin = 1'b0;
	logic [1:0] trip = 2'h0;
	logic [3:0] flt = 4'h0;
	logic [1:0] zc = 2'h0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [31:0] v;
	stc_gate_t [1:0] gate;
	stc_phase_t [1:0] dac_level;
	logic [1:0] decay_mixed;
	int err_total = 0;
	int comparisons = 0;
	int cycles = 0;
	always #5 ref_clk = ~ref_clk;
	stc_ctrl_model ctrl (.ref_clk(ref_clk), .go(go), .dir_req(dir_req), .size_req(size_req),
		.done(done), .step_pin(step_pin), .dir_pin(dir_pin),
		.step_size_select(step_size_select));
	stc_translator_chop dut (.ref_clk(ref_clk), .rst_n(rst_n), .step_pin(step_pin),
		.dir_pin(dir_pin), .step_size_select(step_size_select),
		.translator_reset_n(translator_reset_n), .enable_n(enable_n),
		.off_time_set_pin(off_time_set_pin), .trip(trip), .zero_current(zc),
		.gate_regulator_rail_fault(flt[0]), .charge_pump_rail_uv(flt[1]),
		.overtemp(flt[2]), .undervoltage_lockout(flt[3]), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.gate(gate), .dac_level(dac_level), .decay_mixed(decay_mixed));
	// ==========================================
	// tasks
	task automatic close_out();
		$display("counts: %0d compared, %0d mismatched", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		#1;
		comparisons++;
		if (g !== e)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	task automatic stp(input logic d, input logic s);
		@(posedge ref_clk);
		dir_req <= d;
		size_req <= s;
		go <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		#1;
		for (int n = 0; n < 40 && done !== 1'b1; n++)
			@(posedge ref_clk);
		cyc(6);
	endtask
	// pulse on bridge 0 comparator, then read its chop state
	task automatic tp();
		cyc(1);
		trip <= 2'h1;
		cyc(6);
		trip <= 2'h0;
		cyc(10);
		rd(ADDR_STAT, v);
	endtask
	// ==========================================
	// hang guard
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_total++;
			close_out();
		end
	end
	// ==========================================
	// tests
	initial
	begin
		cyc(10);
		rst_n <= 1'b1;
		cyc(8);
		chk("dac", 6'h09, dac_level);
		chk("decay", 2'h3, decay_mixed);
		chk("gate", 8'h99, gate);
		rd(ADDR_CTRL, v);
		chk("ctrl", {12'h0, RES_RST}, v);
		rd(8'h08, v);
		chk("unmapped", 32'h0, v);
		$display("home test done");
		stp(1'b1, 1'b1);
		chk("dac", 6'h10, dac_level);
		chk("decay", 2'h1, decay_mixed);
		stp(1'b1, 1'b0);
		chk("dac", 6'h0d, dac_level);
		chk("decay", 2'h2, decay_mixed);
		stp(1'b0, 1'b0);
		chk("dac", 6'h09, dac_level);
		chk("decay", 2'h0, decay_mixed);
		$display("step test done");
		cyc(1);
		enable_n <= 1'b1;
		cyc(6);
		chk("gate", 8'h00, gate);
		stp(1'b1, 1'b1);
		chk("dac", 6'h10, dac_level);
		cyc(1);
		translator_reset_n <= 1'b0;
		enable_n <= 1'b0;
		cyc(6);
		chk("dac", 6'h09, dac_level);
		chk("gate", 8'h00, gate);
		stp(1'b1, 1'b1);
		chk("dac", 6'h09, dac_level);
		translator_reset_n <= 1'b1;
		cyc(6);
		chk("gate", 8'h99, gate);
		$display("enable and reset test done");
		for (int i = 0; i < 3; i++)
		begin
			cyc(1);
			flt[i] <= 1'b1;
			cyc(6);
			chk("fault gate", 8'h00, gate);
			flt[i] <= 1'b0;
			cyc(6);
			chk("clear gate", 8'h99, gate);
		end
		stp(1'b1, 1'b1);
		flt[3] <= 1'b1;
		cyc(6);
		chk("gate", 8'h00, gate);
		chk("dac", 6'h09, dac_level);
		flt[3] <= 1'b0;
		$display("fault test done");
		wr(ADDR_CTRL, R_SET);
		rd(ADDR_CTRL, v);
		chk("ctrl", R_SET, v);
		cyc(120);
		tp();
		chk("chop", 2'h2, v[6:5]);
		// bridge 0 in mixed decay, early part reverses, bridge 1 still drives
		chk("fast gate", 8'h96, gate);
		cyc(100);
		chk("slow gate", 8'h95, gate);
		cyc(1);
		zc <= 2'h1;
		cyc(6);
		chk("zero gate", 8'h90, gate);
		zc <= 2'h0;
		cyc(OFF_CYC - 100);
		rd(ADDR_STAT, v);
		chk("chop", 2'h1, v[6:5]);
		tp();
		chk("blanked", 2'h1, v[6:5]);
		cyc(120);
		tp();
		chk("chop", 2'h2, v[6:5]);
		cyc(300);
		off_time_set_pin <= 1'b1;
		cyc(120);
		tp();
		cyc(2500);
		rd(ADDR_STAT, v);
		chk("chop", 2'h2, v[6:5]);
		cyc(600);
		rd(ADDR_STAT, v);
		chk("chop", 2'h1, v[6:5]);
		$display("chop test done");
		close_out();
	end
endmodule
